// [lsc_partner.sv]
`timescale 1ns/100ps

// Strap drivers and interrupt source on the far side of the block
module lsc_partner (
	input  wire logic       interrupt_bus_clock,
	input  wire logic       arst_n,
	input  wire logic       ls_want,
	input  wire logic       ie_want,
	input  wire logic       send,
	input  wire logic [7:0] vec,
	output logic            lockstep_select_strap,
	output logic            intc_enable_strap,
	output logic            irq_valid,
	output logic      [7:0] irq_vector
);
	// Straps follow the bench, which keeps them still around reset release
	assign lockstep_select_strap = ls_want;
	assign intc_enable_strap     = ie_want;

	// One bus-clock pulse; vector kept, though the core captures it along with irq_valid
	always_ff @(posedge interrupt_bus_clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			irq_valid  <= 1'b0;
			irq_vector <= 8'h00;
		end
		else
		begin
			irq_valid  <= send;
			irq_vector <= send ? vec : irq_vector;
		end
	end
endmodule : lsc_partner

// [lsc_pkg.sv]
package lsc_pkg;

	// Strap timing around the falling edge of reset, in core clocks
	localparam int STRAP_SETUP_CLKS = 2;
	localparam int STRAP_HOLD_CLKS  = 2;
	// Least core clocks per interrupt-bus clock period
	localparam int MIN_CLK_RATIO    = 4;
	// Reset value of the latched mode: normal operation
	localparam logic LOCKSTEP_RST   = 1'b0;

	// Interrupt event as seen on the interrupt-bus side
	typedef struct packed {
		logic       valid;
		logic [7:0] vector;
	} lsc_irq_s;

	typedef enum logic [1:0] {
		LSC_IDLE,
		LSC_WAIT,
		LSC_ACCEPT
	} lsc_state_e;

endpackage : lsc_pkg

// [lsc_sync.sv]
`timescale 1ns/100ps

// Two-flop level synchroniser; first stage feeds only the second
module lsc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] q_nxt;

	// Plain shift, no logic between stages
	always_comb
	begin
		meta_nxt = d;
		q_nxt    = meta_r;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_r <= '0;
			q      <= '0;
		end
		else
		begin
			meta_r <= meta_nxt;
			q      <= q_nxt;
		end
	end

endmodule : lsc_sync

// [lsc_top.sv]
`timescale 1ns/100ps

// What this block does
// - Sample lockstep strap at reset falling edge
// - Low or floating strap means normal mode
// - Interrupts accepted on deterministic core clock in lockstep mode
// - Interrupt pins not compared against partner
module lsc_top (
	input  wire logic          clk,
	input  wire logic          arst_n,
	input  wire logic          interrupt_bus_clock,
	input  wire logic          lockstep_select_strap,
	input  wire logic          intc_enable_strap,
	input  wire logic          irq_valid,
	input  wire logic [7:0]    irq_vector,
	output logic               lockstep_mode,
	output logic               intc_enabled,
	output logic               irq_accept,
	output logic      [7:0]    irq_accept_vector
);

	// Bus side: interrupt-bus clock domain, capture request and toggle
	lsc_pkg::lsc_irq_s bus_irq_r;
	lsc_pkg::lsc_irq_s bus_irq_nxt;
	logic              bus_tgl_r;
	logic              bus_tgl_nxt;
	logic              ie_bus_s;

	// Latched enable lives in the core domain; two bus-clock flops before use
	lsc_sync #(
		.WIDTH (1)
	) u_ie_sync (
		.clk    (interrupt_bus_clock),
		.arst_n (arst_n),
		.d      (intc_enabled),
		.q      (ie_bus_s)
	);

	// Hold a captured vector steady until the next event; a toggle marks it
	always_comb
	begin
		bus_irq_nxt = bus_irq_r;
		bus_tgl_nxt = bus_tgl_r;
		if (irq_valid && ie_bus_s)
		begin
			bus_irq_nxt.valid  = 1'b1;
			bus_irq_nxt.vector = irq_vector;
			bus_tgl_nxt        = ~bus_tgl_r;
		end
	end

	always_ff @(posedge interrupt_bus_clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bus_irq_r <= '0;
			bus_tgl_r <= 1'b0;
		end
		else
		begin
			bus_irq_r <= bus_irq_nxt;
			bus_tgl_r <= bus_tgl_nxt;
		end
	end

	// Straps, the toggle and the bus clock level cross into the core domain
	logic [3:0] sync_q;

	lsc_sync #(
		.WIDTH (4)
	) u_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.d      ({interrupt_bus_clock, bus_tgl_r, intc_enable_strap, lockstep_select_strap}),
		.q      (sync_q)
	);

	logic strap_ls_s;
	logic strap_ie_s;
	logic tgl_s;
	logic bclk_s;

	assign strap_ls_s = sync_q[0];
	assign strap_ie_s = sync_q[1];
	assign tgl_s      = sync_q[2];
	assign bclk_s     = sync_q[3];

	// Straps pass two flops before the capture, so an early capture would
	// read reset zeros; stage the capture to the synchroniser depth
	logic [1:0] cap_cnt_r;
	logic [1:0] cap_cnt_nxt;
	logic       mode_r;
	logic       mode_nxt;
	logic       ie_r;
	logic       ie_nxt;

	always_comb
	begin
		cap_cnt_nxt = cap_cnt_r;
		mode_nxt    = mode_r;
		ie_nxt      = ie_r;
		if (cap_cnt_r != 2'h3)
		begin
			cap_cnt_nxt = cap_cnt_r + 2'h1;
			if (cap_cnt_r == 2'h2)
			begin
				mode_nxt = strap_ls_s;
				ie_nxt   = strap_ie_s;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cap_cnt_r <= 2'h0;
			mode_r    <= lsc_pkg::LOCKSTEP_RST;
			ie_r      <= 1'b0;
		end
		else
		begin
			cap_cnt_r <= cap_cnt_nxt;
			mode_r    <= mode_nxt;
			ie_r      <= ie_nxt;
		end
	end

	assign lockstep_mode = mode_r;
	assign intc_enabled  = ie_r;

	// Core side recognition state machine
	lsc_pkg::lsc_state_e st_r;
	lsc_pkg::lsc_state_e st_nxt;
	logic                tgl_seen_r;
	logic                tgl_seen_nxt;
	logic                bclk_d_r;
	logic                bclk_d_nxt;
	logic                acc_r;
	logic                acc_nxt;
	logic [7:0]          vec_r;
	logic [7:0]          vec_nxt;
	logic                bclk_rise;

	// Rising edge of the synchronised bus clock is a fixed core-clock event
	assign bclk_rise = bclk_s & ~bclk_d_r;

	// In lockstep, accept only on a bus clock edge so both cores agree on
	// the cycle; normal mode accepts as soon as the toggle arrives
	always_comb
	begin
		st_nxt       = st_r;
		tgl_seen_nxt = tgl_seen_r;
		bclk_d_nxt   = bclk_s;
		acc_nxt      = 1'b0;
		vec_nxt      = vec_r;
		case (st_r)
			lsc_pkg::LSC_IDLE:
			begin
				if (tgl_s != tgl_seen_r)
				begin
					tgl_seen_nxt = tgl_s;
					st_nxt       = lsc_pkg::LSC_WAIT;
				end
			end
			lsc_pkg::LSC_WAIT:
			begin
				if (!mode_r || bclk_rise)
				begin
					st_nxt = lsc_pkg::LSC_ACCEPT;
				end
			end
			lsc_pkg::LSC_ACCEPT:
			begin
				// Vector held stable by the bus side since the toggle
				acc_nxt = 1'b1;
				vec_nxt = bus_irq_r.vector;
				st_nxt  = lsc_pkg::LSC_IDLE;
			end
			default:
			begin
				st_nxt = lsc_pkg::LSC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_r       <= lsc_pkg::LSC_IDLE;
			tgl_seen_r <= 1'b0;
			bclk_d_r   <= 1'b0;
			acc_r      <= 1'b0;
			vec_r      <= 8'h00;
		end
		else
		begin
			st_r       <= st_nxt;
			tgl_seen_r <= tgl_seen_nxt;
			bclk_d_r   <= bclk_d_nxt;
			acc_r      <= acc_nxt;
			vec_r      <= vec_nxt;
		end
	end

	// No compare logic on interrupt pins; divergence shows on other pins
	assign irq_accept        = acc_r;
	assign irq_accept_vector = vec_r;

	// Assertions
	a_mode_stable: assert property (@(posedge clk) disable iff (!arst_n)
		(cap_cnt_r == 2'h3) |=> $stable(lockstep_mode))
		else $error("lockstep mode changed after capture");

	a_lockstep_edge: assert property (@(posedge clk) disable iff (!arst_n)
		(mode_r && st_r == lsc_pkg::LSC_WAIT && !bclk_rise) |=> (st_r == lsc_pkg::LSC_WAIT))
		else $error("lockstep interrupt accepted off bus clock edge");

	a_accept_pulse: assert property (@(posedge clk) disable iff (!arst_n)
		(st_r == lsc_pkg::LSC_ACCEPT) |=> irq_accept ##1 !irq_accept)
		else $error("accept not a single pulse after accept state");

	a_normal_fast: assert property (@(posedge clk) disable iff (!arst_n)
		(!mode_r && st_r == lsc_pkg::LSC_WAIT) |=> ##1 irq_accept)
		else $error("normal mode accept delayed");

	a_capture_time: assert property (@(posedge clk) disable iff (!arst_n)
		(cap_cnt_r == 2'h2) |=> (lockstep_mode == $past(lockstep_select_strap, 3)))
		else $error("strap not captured at release");

endmodule : lsc_top

// [lsc_top_test.sv]
`timescale 1ns/100ps

module lsc_top_test;
	logic       clk;
	logic       arst_n;
	logic       interrupt_bus_clock;
	logic       ls_want;
	logic       ie_want;
	logic       send;
	logic [7:0] vec;
	logic       lockstep_select_strap;
	logic       intc_enable_strap;
	logic       irq_valid;
	logic [7:0] irq_vector;
	logic       lockstep_mode;
	logic       intc_enabled;
	logic       irq_accept;
	logic [7:0] irq_accept_vector;
	int         errors;
	int         total_checks;
	int         cycles = 0;
	int         lat_a;
	int         lat_b;

	lsc_top uut (.clk(clk), .arst_n(arst_n), .interrupt_bus_clock(interrupt_bus_clock),
		.lockstep_select_strap(lockstep_select_strap), .intc_enable_strap(intc_enable_strap),
		.irq_valid(irq_valid), .irq_vector(irq_vector), .lockstep_mode(lockstep_mode),
		.intc_enabled(intc_enabled), .irq_accept(irq_accept),
		.irq_accept_vector(irq_accept_vector));
	lsc_partner peer (.interrupt_bus_clock(interrupt_bus_clock), .arst_n(arst_n),
		.ls_want(ls_want), .ie_want(ie_want), .send(send), .vec(vec),
		.lockstep_select_strap(lockstep_select_strap), .intc_enable_strap(intc_enable_strap),
		.irq_valid(irq_valid), .irq_vector(irq_vector));

	// Core clock, 20 ns
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Bus clock 160 ns, an integer ratio of 8, offset in phase
	initial
	begin
		interrupt_bus_clock = 1'b0;
		#7;
		forever #80 interrupt_bus_clock = ~interrupt_bus_clock;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize

	// Straps set well before release and held thirty clocks after it
	task automatic do_reset(input logic ls, input logic ie);
		@(negedge clk);
		arst_n  = 1'b0;
		ls_want = ls;
		ie_want = ie;
		repeat (15) @(negedge clk);
		check({6'h00, lockstep_mode, intc_enabled}, 8'h00);
		@(negedge clk);
		arst_n = 1'b1;
		repeat (6) @(negedge clk);
		check({6'h00, lockstep_mode, intc_enabled}, {6'h00, ls, ie});
		// Let the latched enable cross to the bus side before any event
		repeat (24) @(negedge clk);
	endtask : do_reset

	// Latency counted in core clocks from the bus edge that takes the event
	task automatic send_irq(input logic [7:0] v, input logic hit, output int lat);
		logic seen;
		seen = 1'b0;
		lat  = 0;
		@(negedge clk);
		send = 1'b1;
		vec  = v;
		@(posedge interrupt_bus_clock);
		@(negedge clk);
		send = 1'b0;
		for (int i = 1; i < 40 && !seen; i++)
		begin
			if (irq_accept === 1'b1)
			begin
				seen = 1'b1;
				lat  = i;
			end
			else
				@(negedge clk);
		end
		check({7'h00, seen}, {7'h00, hit});
		if (hit)
			check(irq_accept_vector, v);
		repeat (24) @(negedge clk);
	endtask : send_irq

	// Main sequence
	initial
	begin
		arst_n       = 1'b0;
		ls_want      = 1'b0;
		ie_want      = 1'b0;
		send         = 1'b0;
		vec          = 8'h00;
		errors       = 0;
		total_checks = 0;
		// Normal mode; a late strap rise must not switch modes
		do_reset(1'b0, 1'b1);
		send_irq(8'h5a, 1'b1, lat_a);
		ls_want = 1'b1;
		repeat (8) @(negedge clk);
		check({7'h00, lockstep_mode}, 8'h00);
		// Lockstep; straps dropped late, equal latency on both events
		do_reset(1'b1, 1'b1);
		ls_want = 1'b0;
		ie_want = 1'b0;
		send_irq(8'ha5, 1'b1, lat_a);
		send_irq(8'hff, 1'b1, lat_b);
		check(lat_a[7:0], lat_b[7:0]);
		check({6'h00, lockstep_mode, intc_enabled}, 8'h03);
		// Controller strapped off: the event is ignored
		do_reset(1'b0, 1'b0);
		send_irq(8'h33, 1'b0, lat_a);
		summarize();
	end

	// Hang guard; the run needs under 1500 cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			errors++;
			summarize();
		end
	end
endmodule : lsc_top_test
